// file: hdl/rfs_core.sv
// Receive packet filter, receive status and transmit page start.
//
// Contract
// - Reject CRC/alignment errors unless saving errored packets.
// - Runts of eight bytes or more accepted when enabled.
// - All-ones destination accepted only with broadcast enable.
// - Multicast destinations pass the hash filter when enabled.
// - Promiscuous accepts any physical, else station match.
// - Monitor checks packets, counts them, stores nothing.
// - Broadcast, multicast and station matching are OR-ed.
// - Status byte written for good or saved errored packets.
// - Status bits 5 to 0 clear as the next packet starts.
// - Intact set only when no error bit is set.
// - CRC bit covers alignment errors; counted in tally.
// - Alignment error: dribble bits plus bad CRC; counted.
// - FIFO overflow sets overrun and aborts the packet.
// - Missed packet on no buffers or monitor; counted.
// - Address type: zero physical, one multicast.
// - Receiver-disabled follows monitor mode.
// - Deferring follows carrier, collision and jabber.
// - Every register is one byte wide.
// - Page registers hold address bits 15 to 8 only.
// - Transmit DMA starts at page start, low byte zero.
// - Six top CRC bits pick one of 64 filter bits.
// - Station match compares destination byte by byte.
`timescale 1ns/1ns
`default_nettype none
module rfs_core
  import rfs_pkg::*;
#(
  parameter int TALLY_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Received byte stream from the Manchester codec
  input wire logic rx_sof_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,
  input wire logic rx_dribble_i,
  // Buffer and FIFO conditions from neighbouring logic
  input wire logic rx_fifo_overflow_i,
  input wire logic rx_buffer_avail_i,
  // Medium conditions from the codec and transceiver
  input wire logic carrier_sense_i,
  input wire logic collision_i,
  input wire logic jabber_cd_i,
  // Receive results
  output logic rx_addr_ok_o,
  output logic rx_accept_o,
  output logic rx_abort_o,
  output logic rx_done_o,
  output logic rx_status_we_o,
  output logic [7:0] rx_status_o,
  // Transmit local DMA seed
  input wire logic tx_start_i,
  output logic tx_dma_load_o,
  output logic [15:0] tx_dma_addr_o
);

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    rfs_state_t st;
    logic [7:0] cfg;
    logic [7:0] tx_page;
    logic [RFS_NUM_PAR-1:0][7:0] par;
    logic [63:0] mar;
    logic [7:0] status;
    logic [6:0] cnt;
    logic phys_ok;
    logic bcast;
    logic mcast;
    logic hash_pend;
    logic addr_ok;
    logic ack;
    logic [7:0] rdat;
    logic [15:0] dma;
    logic dma_ld;
    logic stat_we;
    logic accept;
    logic abort;
    logic done;
    logic [RFS_NUM_TALLY-1:0] inc;
  } rfs_regs_t;

  rfs_regs_t q;
  rfs_regs_t d;
  logic [31:0] crc;
  logic [5:0] hidx;
  logic [5:0] widx;
  logic wr_en;
  logic [RFS_NUM_TALLY-1:0] tally_clr;
  logic [RFS_NUM_TALLY-1:0][TALLY_WIDTH-1:0] tally;
  logic crc_bad;
  logic len_ok;
  logic keep;
  logic miss;

  // True when an index falls inside a block of registers.
  function automatic logic rfs_in(input logic [5:0] idx,
                                  input logic [5:0] base,
                                  input int num);
    return (idx >= base) && ({26'h0, idx} < {26'h0, base} + num);
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The six most significant CRC bits sit reversed in the low bits
  // of the reflected remainder.
  assign hidx = {crc[0], crc[1], crc[2], crc[3], crc[4], crc[5]};
  assign widx = wb_adr_i[7:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !q.ack;

  // Writing any byte to a tally register clears that tally.
  for (genvar k = 0; k < RFS_NUM_TALLY; k++) begin : g_clr
    assign tally_clr[k] = wr_en && (widx == RFS_IDX_TALLY + 6'(k));
  end

  // End-of-frame verdict from the remainder and the byte count.
  assign crc_bad = (crc != RFS_CRC_RESIDUE);
  assign len_ok = (q.cnt >= RFS_MIN_LEN) ||
                  (q.cfg[RFS_CFG_RUNT] && q.cnt >= RFS_RUNT_MIN);
  assign keep = q.addr_ok && len_ok &&
                (!crc_bad || q.cfg[RFS_CFG_SAVE]);
  assign miss = keep &&
                (q.cfg[RFS_CFG_MONITOR] || !rx_buffer_avail_i);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.dma_ld = 1'b0;
    d.stat_we = 1'b0;
    d.accept = 1'b0;
    d.abort = 1'b0;
    d.done = 1'b0;
    d.inc = '0;

    // Live medium and mode flags in the status byte.
    // These two bits are not cleared by a new frame; they track the
    // medium and the mode one cycle behind.
    d.status[RFS_ST_DEFER] = carrier_sense_i || collision_i ||
                             jabber_cd_i;
    d.status[RFS_ST_RX_OFF] = q.cfg[RFS_CFG_MONITOR];

    // Bus access: answer once, one cycle after the request.
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.rdat = 8'h00;
      if (widx == RFS_IDX_RX_CFG) begin
        d.rdat = q.status;
      end else if (rfs_in(widx, RFS_IDX_TALLY, RFS_NUM_TALLY)) begin
        d.rdat = 8'(tally[widx - RFS_IDX_TALLY]);
      end else if (widx == RFS_IDX_TX_PAGE) begin
        d.rdat = q.tx_page;
      end else if (rfs_in(widx, RFS_IDX_PAR, RFS_NUM_PAR)) begin
        d.rdat = q.par[widx - RFS_IDX_PAR];
      end else if (rfs_in(widx, RFS_IDX_MAR, RFS_NUM_MAR)) begin
        d.rdat = q.mar[8 * (widx - RFS_IDX_MAR) +: 8];
      end
    end

    // Register writes take the low byte lane only.
    if (wr_en) begin
      if (widx == RFS_IDX_RX_CFG) begin
        d.cfg = wb_dat_i[7:0] & RFS_CFG_MASK;
      end else if (widx == RFS_IDX_TX_PAGE) begin
        d.tx_page = wb_dat_i[7:0];
      end else if (rfs_in(widx, RFS_IDX_PAR, RFS_NUM_PAR)) begin
        d.par[widx - RFS_IDX_PAR] = wb_dat_i[7:0];
      end else if (rfs_in(widx, RFS_IDX_MAR, RFS_NUM_MAR)) begin
        d.mar[8 * (widx - RFS_IDX_MAR) +: 8] = wb_dat_i[7:0];
      end
    end

    // Transmit start seeds the local DMA on a page boundary.
    if (tx_start_i) begin
      d.dma = {q.tx_page, 8'h00};
      d.dma_ld = 1'b1;
    end

    // Receive sequencer: overflow first, then a new frame.
    if (rx_fifo_overflow_i && q.st != RFS_IDLE) begin
      // An aborted frame never reaches the end-of-frame verdict, so
      // the overrun bit is the only record that it was seen.
      d.status[RFS_ST_OVERRUN] = 1'b1;
      d.status[RFS_ST_INTACT] = 1'b0;
      d.abort = 1'b1;
      d.addr_ok = 1'b0;
      d.st = RFS_IDLE;
    end else if (rx_sof_i) begin
      d.status[5:0] = 6'h00;
      d.cnt = 7'd0;
      d.phys_ok = 1'b1;
      d.bcast = 1'b1;
      d.mcast = 1'b0;
      d.hash_pend = 1'b0;
      d.addr_ok = 1'b0;
      d.st = RFS_ADDR;
    end else begin
      case (q.st)
        RFS_IDLE: begin
          d.st = RFS_IDLE;
        end
        RFS_ADDR: begin
          if (rx_eof_i) begin
            d.st = RFS_DONE;
            d.done = 1'b1;
          end else if (rx_byte_valid_i) begin
            d.cnt = q.cnt + 7'd1;
            d.phys_ok = q.phys_ok &&
                        (rx_byte_i == q.par[q.cnt[2:0]]);
            d.bcast = q.bcast && (rx_byte_i == 8'hFF);
            if (q.cnt == 7'd0) begin
              d.mcast = rx_byte_i[0];
            end
            if (q.cnt == RFS_LAST_DA) begin
              d.hash_pend = 1'b1;
              d.st = RFS_DATA;
            end
          end
        end
        RFS_DATA: begin
          // The remainder after the last address byte is ready now.
          if (q.hash_pend) begin
            d.hash_pend = 1'b0;
            // Each address class has its own enable, so the classes
            // combine as an OR; broadcast never falls through to the
            // hash filter, which keeps an all-ones hash bit harmless.
            if (q.mcast) begin
              d.addr_ok = q.bcast ? q.cfg[RFS_CFG_BCAST]
                        : (q.cfg[RFS_CFG_MCAST] && q.mar[hidx]);
            end else begin
              d.addr_ok = q.cfg[RFS_CFG_PROMISC] || q.phys_ok;
            end
          end
          if (rx_eof_i) begin
            d.st = RFS_DONE;
            d.done = 1'b1;
            // Status bits are updated for rejected frames as well.
            d.status[RFS_ST_CRC] = crc_bad;
            d.status[RFS_ST_ALIGN] = crc_bad && rx_dribble_i;
            d.status[RFS_ST_MISSED] = miss;
            d.status[RFS_ST_ADDR_TYPE] = q.mcast;
            d.status[RFS_ST_INTACT] = !crc_bad && !miss;
            d.accept = keep && !miss;
            d.stat_we = keep && !miss;
            d.inc[RFS_TALLY_CRC] = q.addr_ok && crc_bad;
            d.inc[RFS_TALLY_ALN] = q.addr_ok && crc_bad &&
                                   rx_dribble_i;
            d.inc[RFS_TALLY_MISS] = miss;
          end else if (rx_byte_valid_i && q.cnt < RFS_MIN_LEN) begin
            d.cnt = q.cnt + 7'd1;
          end
        end
        RFS_DONE: begin
          d.st = RFS_IDLE;
        end
        default: begin
          d.st = RFS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= RFS_IDLE;
      q.cfg <= RFS_RST_BYTE;
      // Status is cleared here although software may not rely on it
      // before the first frame.
      q.tx_page <= RFS_RST_BYTE;
      q.mar <= RFS_RST_MAR;
      q.status <= RFS_RST_BYTE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Frame check engine and tally counters
  // ----------------------------------------------------------------
  rfs_crc u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(rx_sof_i),
    .en_i(rx_byte_valid_i && q.st != RFS_IDLE),
    .byte_i(rx_byte_i),
    .crc_o(crc)
  );

  // One tally each for alignment, CRC and missed packets.
  for (genvar k = 0; k < RFS_NUM_TALLY; k++) begin : g_tally
    rfs_tally #(
      .WIDTH(TALLY_WIDTH)
    ) u_tally (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(q.inc[k]),
      .clr_i(tally_clr[k]),
      .count_o(tally[k])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answers and receive results come straight from flip-flops.
  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.rdat};
  assign rx_addr_ok_o = q.addr_ok;
  assign rx_accept_o = q.accept;
  assign rx_abort_o = q.abort;
  assign rx_done_o = q.done;
  assign rx_status_we_o = q.stat_we;
  assign rx_status_o = q.status;
  assign tx_dma_load_o = q.dma_ld;
  assign tx_dma_addr_o = q.dma;

endmodule // rfs_core
`default_nettype wire

// file: hdl/rfs_pkg.sv
// Constants and types shared by the receive filter and status block.
package rfs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] RFS_IDX_RX_CFG = 6'h0C;
  localparam logic [5:0] RFS_IDX_TALLY = 6'h0D;
  localparam logic [5:0] RFS_IDX_TX_PAGE = 6'h10;
  localparam logic [5:0] RFS_IDX_PAR = 6'h11;
  localparam logic [5:0] RFS_IDX_MAR = 6'h18;
  localparam int RFS_NUM_TALLY = 3;
  localparam int RFS_NUM_PAR = 6;
  localparam int RFS_NUM_MAR = 8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RFS_CFG_SAVE = 0;
  localparam int RFS_CFG_RUNT = 1;
  localparam int RFS_CFG_BCAST = 2;
  localparam int RFS_CFG_MCAST = 3;
  localparam int RFS_CFG_PROMISC = 4;
  localparam int RFS_CFG_MONITOR = 5;
  localparam logic [7:0] RFS_CFG_MASK = 8'h3F;
  localparam int RFS_ST_INTACT = 0;
  localparam int RFS_ST_CRC = 1;
  localparam int RFS_ST_ALIGN = 2;
  localparam int RFS_ST_OVERRUN = 3;
  localparam int RFS_ST_MISSED = 4;
  localparam int RFS_ST_ADDR_TYPE = 5;
  localparam int RFS_ST_RX_OFF = 6;
  localparam int RFS_ST_DEFER = 7;
  localparam int RFS_TALLY_ALN = 0;
  localparam int RFS_TALLY_CRC = 1;
  localparam int RFS_TALLY_MISS = 2;
  localparam logic [7:0] RFS_RST_BYTE = 8'h00;
  localparam logic [63:0] RFS_RST_MAR = 64'h0;

  // ----------------------------------------------------------------
  // Frame lengths and frame check sequence
  // ----------------------------------------------------------------
  localparam logic [6:0] RFS_MIN_LEN = 7'd64;
  localparam logic [6:0] RFS_RUNT_MIN = 7'd8;
  localparam logic [6:0] RFS_LAST_DA = 7'd5;
  localparam logic [31:0] RFS_CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] RFS_CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] RFS_CRC_RESIDUE = 32'hDEBB20E3;

  // Receive sequencer states, Gray coded along the frame path.
  typedef enum logic [1:0] {
    RFS_IDLE = 2'b00,
    RFS_ADDR = 2'b01,
    RFS_DATA = 2'b11,
    RFS_DONE = 2'b10
  } rfs_state_t;

endpackage

// file: hdl/rfs_crc.sv
// Byte-wide frame check sequence engine, least significant bit first.
`timescale 1ns/1ns
`default_nettype none
module rfs_crc
  import rfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte stream
  input wire logic init_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  // Running remainder
  output logic [31:0] crc_o
);

  // One byte of the reflected polynomial division.
  function automatic logic [31:0] rfs_step(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ RFS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Restarts at each frame and folds in every received byte.
  always_ff @(posedge clk_i) begin
    if (rst_i || init_i) begin
      crc_o <= RFS_CRC_INIT;
    end else if (en_i) begin
      crc_o <= rfs_step(crc_o, byte_i);
    end
  end

endmodule // rfs_crc
`default_nettype wire

// file: hdl/rfs_tally.sv
// Saturating event tally counter with software clear.
`timescale 1ns/1ns
`default_nettype none
module rfs_tally #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events
  input wire logic inc_i,
  input wire logic clr_i,
  // Count
  output logic [WIDTH-1:0] count_o
);

  // An event in the clearing cycle is kept as a count of one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (clr_i) begin
      count_o <= {{(WIDTH-1){1'b0}}, inc_i};
    end else if (inc_i && !(&count_o)) begin
      count_o <= count_o + 1'b1;
    end
  end

endmodule // rfs_tally
`default_nettype wire

// file: dv/rfs_core_monitor.sv
// Port checker for the receive filter and status core.
`timescale 1ns/1ns
`default_nettype none
module rfs_core_monitor
  import rfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Receive side
  input wire logic rx_sof_i,
  input wire logic carrier_sense_i,
  input wire logic collision_i,
  input wire logic jabber_cd_i,
  input wire logic rx_accept_o,
  input wire logic rx_abort_o,
  input wire logic rx_done_o,
  input wire logic rx_status_we_o,
  input wire logic [7:0] rx_status_o,
  // Transmit seed
  input wire logic tx_start_i,
  input wire logic tx_dma_load_o,
  input wire logic [15:0] tx_dma_addr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  // Some properties tie an output to the input event that causes it; the others relate outputs to each other.
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer missing");
  chk_ack_byte: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000 ##1 !wb_ack_o)
    else $error("bus answer not one byte pulse");
  chk_sof_clear: assert property (
    rx_sof_i |=> rx_status_o[5:0] == 6'h00)
    else $error("status not cleared at frame start");
  chk_intact_clean: assert property (
    rx_status_o[RFS_ST_INTACT] |-> rx_status_o[4:1] == 4'h0)
    else $error("intact with error bit");
  chk_align_crc: assert property (
    rx_status_o[RFS_ST_ALIGN] |-> rx_status_o[RFS_ST_CRC])
    else $error("alignment without crc bit");
  chk_abort_fo: assert property (
    rx_abort_o |-> rx_status_o[RFS_ST_OVERRUN] && !rx_accept_o)
    else $error("abort without overrun");
  chk_store_ok: assert property (
    rx_status_we_o |-> rx_done_o && !rx_status_o[RFS_ST_MISSED])
    else $error("status stored for missed frame");
  chk_accept_kept: assert property (
    rx_accept_o |-> rx_done_o && !rx_status_o[RFS_ST_MISSED])
    else $error("accept with missed bit");
  chk_defer_set: assert property (
    carrier_sense_i || collision_i || jabber_cd_i
    |=> rx_status_o[RFS_ST_DEFER])
    else $error("deferring not set");
  chk_tx_page: assert property (
    tx_start_i |=> tx_dma_load_o && tx_dma_addr_o[7:0] == 8'h00)
    else $error("transmit seed wrong");
endmodule // rfs_core_monitor

bind rfs_core rfs_core_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_sof_i(rx_sof_i),
  .carrier_sense_i(carrier_sense_i), .collision_i(collision_i),
  .jabber_cd_i(jabber_cd_i), .rx_accept_o(rx_accept_o),
  .rx_abort_o(rx_abort_o), .rx_done_o(rx_done_o),
  .rx_status_we_o(rx_status_we_o), .rx_status_o(rx_status_o),
  .tx_start_i(tx_start_i), .tx_dma_load_o(tx_dma_load_o),
  .tx_dma_addr_o(tx_dma_addr_o));
`default_nettype wire

// file: dv/rfs_medium_model.sv
// Byte stream model of the network side behind the Manchester codec.
`timescale 1ns/1ns
`default_nettype none
module rfs_medium_model (
  // Clock
  input wire logic clk_i,
  // Byte stream into the receiver
  output logic sof_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic eof_o,
  output logic dribble_o,
  output logic overflow_o
);
  // Idle levels at time zero.
  initial begin
    {sof_o, byte_valid_o, eof_o, dribble_o, overflow_o} = 5'h00;
    byte_o = 8'h00;
  end
  // Sends a frame; byte and dribble lines carry the inverse once a value is taken.
  task automatic send(input logic [7:0] fr[$], input logic drib,
                      input int ovf);
    @(posedge clk_i) sof_o <= 1'b1;
    @(posedge clk_i) sof_o <= 1'b0;
    foreach (fr[i]) begin
      @(posedge clk_i);
      byte_valid_o <= 1'b1;
      byte_o <= fr[i];
      overflow_o <= (i == ovf);
      @(posedge clk_i);
      byte_valid_o <= 1'b0;
      byte_o <= ~fr[i];
      overflow_o <= 1'b0;
    end
    @(posedge clk_i);
    eof_o <= 1'b1;
    dribble_o <= drib;
    @(posedge clk_i);
    eof_o <= 1'b0;
    dribble_o <= ~drib;
  endtask
endmodule // rfs_medium_model
`default_nettype wire

// file: dv/tb_receive_filter_status.sv
// Self-checking bench for the receive filter and status core.
`timescale 1ns/1ns
`default_nettype none
module tb_receive_filter_status
  import rfs_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, cfg = 8'h00, tp, r;
  logic [3:0] sel = 4'hF;
  logic [31:0] dw = 32'h0, dr;
  logic ack, sof, bv, eof, drb, ovf, aok, acc, abt, done, swe, load;
  logic bav = 1'b1, cs = 1'b0, col = 1'b0, jab = 1'b0, tst = 1'b0;
  logic [7:0] rb, st;
  logic [15:0] txa;
  logic [47:0] sta;
  logic [63:0] mar;
  int n_mismatch = 0, num_checks = 0, tal[3] = '{0, 0, 0};
  // Clock and hang guard.
  always #4 clk_i = ~clk_i;
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  rfs_medium_model i_med (.clk_i(clk_i), .sof_o(sof), .byte_valid_o(bv),
    .byte_o(rb), .eof_o(eof), .dribble_o(drb), .overflow_o(ovf));
  rfs_core #(.TALLY_WIDTH(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .rx_sof_i(sof), .rx_byte_valid_i(bv), .rx_byte_i(rb), .rx_eof_i(eof),
    .rx_dribble_i(drb), .rx_fifo_overflow_i(ovf), .rx_buffer_avail_i(bav),
    .carrier_sense_i(cs), .collision_i(col), .jabber_cd_i(jab),
    .rx_addr_ok_o(aok), .rx_accept_o(acc), .rx_abort_o(abt),
    .rx_done_o(done), .rx_status_we_o(swe), .rx_status_o(st),
    .tx_start_i(tst), .tx_dma_load_o(load), .tx_dma_addr_o(txa));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compares and counts one result.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single bus cycle; holds the request until ack is sampled.
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {i, 2'b00};
    dw <= {24'h000000, d};
    do @(posedge clk_i); while (!ack && n++ < 20);
    q = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk("wb_ack_o", 1'b1, 1'b0);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wb(1'b1, i, d, 4'hF, r);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e, input string nm);
    wb(1'b0, i, 8'h00, 4'hF, r);
    chk(nm, e, r);
  endtask
  // Bit-serial frame check sequence, first bit on the wire first.
  function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
    for (int k = 0; k < 8; k++)
      c = (c >> 1) ^ ((c[0] ^ b[k]) ? RFS_CRC_POLY : 32'h0);
    return c;
  endfunction
  // Builds a frame, predicts the filter verdict, sends and checks it.
  task automatic frame(input int k, input int len, input logic bad,
                       input logic dv, input int ov);
    logic [7:0] q[$];
    logic [47:0] da;
    logic [31:0] c;
    logic ok, el, miss, keep;
    da = (k == 0) ? sta : (k == 1) ? '1 : 48'({$urandom, $urandom});
    if (k > 1) da[0] = (k == 2);
    c = RFS_CRC_INIT;
    for (int i = 0; i < len - 4; i++) begin
      q.push_back(i < 6 ? da[8*i +: 8] : 8'($urandom));
      c = crc_upd(c, q[i]);
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
    da = {q[5], q[4], q[3], q[2], q[1], q[0]};
    c = RFS_CRC_INIT;
    for (int i = 0; i < 6; i++) c = crc_upd(c, q[i]);
    if (&da) ok = cfg[RFS_CFG_BCAST];
    else if (da[0])
      ok = cfg[RFS_CFG_MCAST] && mar[{c[0], c[1], c[2], c[3], c[4], c[5]}];
    else ok = cfg[RFS_CFG_PROMISC] || da == sta;
    el = ok && (len >= 64 || (cfg[RFS_CFG_RUNT] && len >= 8));
    el = el && (!bad || cfg[RFS_CFG_SAVE]);
    miss = el && (!bav || cfg[RFS_CFG_MONITOR]);
    keep = el && !miss && ov < 0;
    i_med.send(q, dv, ov);
    // The end-of-frame pulses stand only in the cycle after eof.
    #1;
    chk("rx_accept_o", keep, acc);
    if (ov >= 0) chk("overrun_bit", 1'b1, st[RFS_ST_OVERRUN]);
    else begin
      chk("rx_done_o", 1'b1, done);
      chk("rx_addr_ok_o", ok, aok);
      chk("rx_status_we_o", keep, swe);
      chk("crc_bit", bad, st[RFS_ST_CRC]);
      chk("align_bit", bad & dv, st[RFS_ST_ALIGN]);
      chk("miss_bit", miss, st[RFS_ST_MISSED]);
      if (keep) chk("intact_bit", !bad, st[RFS_ST_INTACT]);
      if (ok) chk("type_bit", da[0], st[RFS_ST_ADDR_TYPE]);
      if (ok) tal[1] += bad;
      if (ok) tal[0] += bad & dv;
      tal[2] += miss;
    end
  endtask
  task automatic scfg(input logic [7:0] v);
    cfg = v;
    wr(RFS_IDX_RX_CFG, v);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(90));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(RFS_IDX_RX_CFG, RFS_RST_BYTE, "status_reset");
    rd(RFS_IDX_TX_PAGE, RFS_RST_BYTE, "page_reset");
    rd(6'h3F, 8'h00, "unmapped");
    tp = 8'($urandom);
    wr(RFS_IDX_TX_PAGE, tp);
    wb(1'b1, RFS_IDX_TX_PAGE, ~tp, 4'h0, r);
    rd(RFS_IDX_TX_PAGE, tp, "page_start");
    @(posedge clk_i) tst <= 1'b1;
    @(posedge clk_i) tst <= 1'b0;
    #1;
    chk("tx_dma_addr_o", {tp, 8'h00}, load ? txa : 16'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) {jab, col, cs} <= 3'(1 << i);
      rd(RFS_IDX_RX_CFG, 8'h80, "defer_on");
      @(posedge clk_i) {jab, col, cs} <= 3'h0;
      rd(RFS_IDX_RX_CFG, 8'h00, "defer_off");
    end
    sta = 48'({$urandom, $urandom}) & ~48'h1;
    mar = {$urandom, $urandom};
    for (int i = 0; i < 6; i++) wr(RFS_IDX_PAR + 6'(i), sta[8*i +: 8]);
    for (int i = 0; i < 8; i++) wr(RFS_IDX_MAR + 6'(i), mar[8*i +: 8]);
    repeat (60) begin
      @(posedge clk_i) bav <= ($urandom_range(5) != 0);
      scfg(8'($urandom) & 8'hDF);
      frame($urandom_range(3), $urandom_range(10, 72), $urandom_range(3) == 0,
            1'b0, -1);
    end
    @(posedge clk_i) bav <= 1'b1;
    scfg(8'h21);
    wb(1'b0, RFS_IDX_RX_CFG, 8'h00, 4'hF, r);
    chk("disabled_on", 1'b1, r[RFS_ST_RX_OFF]);
    frame(0, 64, 1'b0, 1'b0, -1);
    frame(0, 64, 1'b1, 1'b1, -1);
    scfg(8'h00);
    wb(1'b0, RFS_IDX_RX_CFG, 8'h00, 4'hF, r);
    chk("disabled_off", 1'b0, r[RFS_ST_RX_OFF]);
    frame(0, 63, 1'b0, 1'b0, -1);
    frame(0, 64, 1'b0, 1'b0, 10);
    scfg(8'h12);
    frame(3, 7, 1'b0, 1'b0, -1);
    frame(3, 8, 1'b0, 1'b0, -1);
    mar = '1;
    for (int i = 0; i < 8; i++) wr(RFS_IDX_MAR + 6'(i), 8'hFF);
    scfg(8'h1C);
    for (int i = 0; i < 4; i++) frame(i, 64, 1'b0, 1'b0, -1);
    for (int i = 0; i < 3; i++) rd(RFS_IDX_TALLY + 6'(i), 8'(tal[i]), "tally");
    report_and_stop();
  end
endmodule // tb_receive_filter_status
`default_nettype wire
